// file: verilog/psfs_pkg.sv
// Shared constants and types for the power supply fault supervisor
`default_nettype none
package psfs_pkg;

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  localparam real CLK_MHZ = 40.0;

  // ----------------------------------------------------------------
  // Times as printed, and their cycle counts (least times round up)
  // ----------------------------------------------------------------
  localparam real DEBOUNCE_MS = 38.0;
  localparam real UV_BLANK_MS = 75.0;
  localparam real TURNOFF_MS = 2.3;
  localparam real UV_GLITCH_US = 146.0;
  localparam real OV_GLITCH_US = 73.0;
  localparam real PG_SHORT_MS = 150.0;
  localparam real PG_LONG_MS = 300.0;
  localparam real PG_FALL_US = 150.0;

  localparam int DEBOUNCE_CYC = int'($ceil(DEBOUNCE_MS * 1000.0 * CLK_MHZ));
  localparam int UV_BLANK_CYC = int'($ceil(UV_BLANK_MS * 1000.0 * CLK_MHZ));
  localparam int TURNOFF_CYC = int'($ceil(TURNOFF_MS * 1000.0 * CLK_MHZ));
  localparam int UV_GLITCH_CYC = int'($ceil(UV_GLITCH_US * CLK_MHZ));
  localparam int OV_GLITCH_CYC = int'($ceil(OV_GLITCH_US * CLK_MHZ));
  localparam int PG_SHORT_CYC = int'($ceil(PG_SHORT_MS * 1000.0 * CLK_MHZ));
  localparam int PG_LONG_CYC = int'($ceil(PG_LONG_MS * 1000.0 * CLK_MHZ));
  localparam int PG_FALL_CYC = int'($ceil(PG_FALL_US * CLK_MHZ));

  // ----------------------------------------------------------------
  // Reset values and widths
  // ----------------------------------------------------------------
  localparam int CNT_W = 32;
  localparam int NUM_RAILS = 5;
  localparam int NUM_UV = 2;
  localparam logic REQ_RST = 1'b1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Comparator flags; the low NUM_UV bits are undervoltage flags
  typedef struct packed {
    logic ov_12v;
    logic ov_5v;
    logic ov_3v3;
    logic uv_5v;
    logic uv_3v3;
  } psfs_rail_flags_t;

  typedef enum logic [1:0] {
    PSFS_OFF = 2'b00,
    PSFS_BLANK = 2'b01,
    PSFS_RUN = 2'b11,
    PSFS_STOP = 2'b10
  } psfs_state_t;

endpackage
`default_nettype wire

// file: verilog/psfs_filter.sv
// Asymmetric persistence filter: output follows input only after it has held
`timescale 1ns/1ps
`default_nettype none
module psfs_filter #(
  parameter int RISE_CYC = 1,
  parameter int FALL_CYC = 1,
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_i,   // Timebase clock
  input wire logic rstn_i,  // Async reset, active low
  input wire logic raw_i,   // Unfiltered level
  output logic filt_o       // Filtered level
);

  logic [psfs_pkg::CNT_W-1:0] cnt_q;
  logic [psfs_pkg::CNT_W-1:0] cnt_d;
  logic filt_q;
  logic filt_d;
  logic [psfs_pkg::CNT_W-1:0] limit;

  always_comb
  begin
    limit = raw_i ? psfs_pkg::CNT_W'(RISE_CYC - 1) : psfs_pkg::CNT_W'(FALL_CYC - 1);
    cnt_d = '0;
    filt_d = filt_q;
    // Any return to the current level restarts the count, rejecting glitches
    if (raw_i != filt_q)
    begin
      if (cnt_q >= limit)
      begin
        filt_d = raw_i;
      end
      else
      begin
        cnt_d = cnt_q + psfs_pkg::CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_q <= '0;
      filt_q <= RST_VAL;
    end
    else
    begin
      cnt_q <= cnt_d;
      filt_q <= filt_d;
    end
  end

  assign filt_o = filt_q;

endmodule
`default_nettype wire

// file: verilog/psfs_supervisor.sv
// Power supply fault supervisor: on/off control, fault latch, power good
//
// Function
// R1: A detected fault is latched, holding fault-protect high until a request rise or reset.
// R2: Each on/off request transition must stay stable for 38 ms before it acts.
// R3: Undervoltage is ignored for 75 ms after the debounced request goes low.
// R4: After the debounced request goes high, fault-protect stays low 2.3 ms more, then goes high.
// R5: Fault-protect is low, enabling rails, only while the request is low and no fault is latched; the code also holds it low in the STOP turn-off delay.
// R6: Undervoltage on 3.3 V or 5 V persisting over 146 us latches a fault and drops power good.
// R7: Overvoltage on 3.3 V, 5 V or 12 V held over 73 us latches a fault and drops power good.
// R8: Fault-protect is high whenever the request is high or open; the code holds it low through the STOP turn-off delay first.
// R9: Power good rises 150 ms or 300 ms after the power-good input and both rails are healthy.
// R10: Power good drops once the input or a rail has been low for 150 us.
// R11: Rail flags are synchronous inputs and all intervals are counted on the clock.
`timescale 1ns/1ps
`default_nettype none
module psfs_supervisor #(
  parameter logic LONG_PG_DELAY = 1'b0,                  // 1: long power good delay
  parameter int DEBOUNCE_CYC = psfs_pkg::DEBOUNCE_CYC,
  parameter int UV_BLANK_CYC = psfs_pkg::UV_BLANK_CYC,
  parameter int TURNOFF_CYC = psfs_pkg::TURNOFF_CYC,
  parameter int UV_GLITCH_CYC = psfs_pkg::UV_GLITCH_CYC,
  parameter int OV_GLITCH_CYC = psfs_pkg::OV_GLITCH_CYC,
  parameter int PG_SHORT_CYC = psfs_pkg::PG_SHORT_CYC,
  parameter int PG_LONG_CYC = psfs_pkg::PG_LONG_CYC,
  parameter int PG_FALL_CYC = psfs_pkg::PG_FALL_CYC
) (
  input wire logic clk_i,                          // Timebase clock, 40 MHz
  input wire logic rstn_i,                         // Async reset (supply loss), active low
  input wire logic on_off_request_n_i,             // Remote on/off pin, active low
  input wire logic power_good_in_i,                // Power-good input comparator, sync
  input wire psfs_pkg::psfs_rail_flags_t rail_i,   // Rail comparator flags, sync
  output logic fault_protect_n_o,                  // Fault-protect level, high = rails off
  output logic fault_protect_n_oe_o,               // Open-drain pull-low enable
  output logic power_good_out_o,                   // Power good level
  output logic power_good_out_oe_o,                // Open-drain pull-low enable
  output logic fault_latched_o                     // Fault latch state
);

  // ----------------------------------------------------------------
  // Request synchroniser and debounce
  // ----------------------------------------------------------------
  logic req_meta_q;
  logic req_sync_q;
  logic req_db_n;
  logic req_db_prev_q;
  logic req_rise;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      req_meta_q <= psfs_pkg::REQ_RST;
      req_sync_q <= psfs_pkg::REQ_RST;
      req_db_prev_q <= psfs_pkg::REQ_RST;
    end
    else
    begin
      req_meta_q <= on_off_request_n_i;
      req_sync_q <= req_meta_q;
      req_db_prev_q <= req_db_n;
    end
  end

  psfs_filter #(
    .RISE_CYC(DEBOUNCE_CYC),
    .FALL_CYC(DEBOUNCE_CYC),
    .RST_VAL(psfs_pkg::REQ_RST)
  ) u_req_db (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .raw_i(req_sync_q),
    .filt_o(req_db_n)
  ); // R2

  assign req_rise = req_db_n & ~req_db_prev_q;

  // ----------------------------------------------------------------
  // Rail deglitch
  // ----------------------------------------------------------------
  logic [psfs_pkg::NUM_RAILS-1:0] rail_raw;
  logic [psfs_pkg::NUM_RAILS-1:0] rail_flt;
  logic uv_any;
  logic ov_any;

  assign rail_raw = rail_i;

  // Faults persist to assert but clear at once, so a recovering rail is not held bad
  for (genvar g = 0; g < psfs_pkg::NUM_RAILS; g++)
  begin : g_rail
    psfs_filter #(
      .RISE_CYC((g < psfs_pkg::NUM_UV) ? UV_GLITCH_CYC : OV_GLITCH_CYC),
      .FALL_CYC(1),
      .RST_VAL(1'b0)
    ) u_rail (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .raw_i(rail_raw[g]),
      .filt_o(rail_flt[g])
    ); // R6 R7 R11
  end

  assign uv_any = |rail_flt[psfs_pkg::NUM_UV-1:0];
  assign ov_any = |rail_flt[psfs_pkg::NUM_RAILS-1:psfs_pkg::NUM_UV];

  // ----------------------------------------------------------------
  // Sequencer and fault latch
  // ----------------------------------------------------------------
  psfs_pkg::psfs_state_t state_q;
  psfs_pkg::psfs_state_t state_d;
  logic [psfs_pkg::CNT_W-1:0] tmr_q;
  logic [psfs_pkg::CNT_W-1:0] tmr_d;
  logic fault_q;
  logic fault_d;
  logic fault_set;

  // Undervoltage counts only in RUN, which starts after the turn-on blanking window
  assign fault_set = ov_any | (uv_any & (state_q == psfs_pkg::PSFS_RUN)); // R3 R6 R7

  always_comb
  begin
    state_d = state_q;
    tmr_d = '0;
    case (state_q)
      psfs_pkg::PSFS_OFF:
      begin
        if (!req_db_n)
        begin
          state_d = psfs_pkg::PSFS_BLANK;
        end
      end
      psfs_pkg::PSFS_BLANK:
      begin
        if (req_db_n)
        begin
          state_d = psfs_pkg::PSFS_STOP;
        end
        else if (tmr_q >= psfs_pkg::CNT_W'(UV_BLANK_CYC - 1))
        begin
          state_d = psfs_pkg::PSFS_RUN; // R3
        end
        else
        begin
          tmr_d = tmr_q + psfs_pkg::CNT_W'(1);
        end
      end
      psfs_pkg::PSFS_RUN:
      begin
        if (req_db_n)
        begin
          state_d = psfs_pkg::PSFS_STOP;
        end
      end
      psfs_pkg::PSFS_STOP:
      begin
        if (!req_db_n)
        begin
          state_d = psfs_pkg::PSFS_BLANK;
        end
        else if (tmr_q >= psfs_pkg::CNT_W'(TURNOFF_CYC - 1))
        begin
          state_d = psfs_pkg::PSFS_OFF; // R4
        end
        else
        begin
          tmr_d = tmr_q + psfs_pkg::CNT_W'(1);
        end
      end
      default:
      begin
        state_d = psfs_pkg::PSFS_OFF;
      end
    endcase
    // Set wins over the clearing edge so a coincident fault is kept
    fault_d = fault_set | (fault_q & ~req_rise); // R1
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_q <= psfs_pkg::PSFS_OFF;
      tmr_q <= '0;
      fault_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      fault_q <= fault_d;
    end
  end

  // ----------------------------------------------------------------
  // Power good delay and outputs
  // ----------------------------------------------------------------
  logic pg_raw;
  logic pg_flt;
  logic fpo_n_q;
  logic fpo_n_d;
  logic pg_q;
  logic pg_d;

  assign pg_raw = power_good_in_i & ~rail_raw[0] & ~rail_raw[1];

  psfs_filter #(
    .RISE_CYC(LONG_PG_DELAY ? PG_LONG_CYC : PG_SHORT_CYC),
    .FALL_CYC(PG_FALL_CYC),
    .RST_VAL(1'b0)
  ) u_pg (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .raw_i(pg_raw),
    .filt_o(pg_flt)
  ); // R9 R10

  always_comb
  begin
    fpo_n_d = (state_q == psfs_pkg::PSFS_OFF) | fault_q | fault_set; // R5 R8
    pg_d = pg_flt & ~fault_q & ~fault_set & (state_q == psfs_pkg::PSFS_RUN); // R6 R7 R9
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      fpo_n_q <= 1'b1;
      pg_q <= 1'b0;
    end
    else
    begin
      fpo_n_q <= fpo_n_d;
      pg_q <= pg_d;
    end
  end

  assign fault_protect_n_o = fpo_n_q;
  assign fault_protect_n_oe_o = ~fpo_n_q;
  assign power_good_out_o = pg_q;
  assign power_good_out_oe_o = ~pg_q;
  assign fault_latched_o = fault_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  fault_hold_a: assert property (fault_q && !req_rise |=> fault_q) // R1
    else $error("fault latch dropped without request edge");
  fault_fpo_a: assert property (fault_q |=> fault_protect_n_o) // R1
    else $error("fault latched but rails enabled");
  turnon_db_a: assert property ( // R2
    (state_q == psfs_pkg::PSFS_OFF) && req_db_n |=> state_q != psfs_pkg::PSFS_BLANK)
    else $error("turn-on without debounced request");
  blank_uv_a: assert property ( // R3
    (state_q == psfs_pkg::PSFS_BLANK) && !ov_any && !fault_q |=> !fault_q)
    else $error("undervoltage acted during blanking");
  // An overvoltage may legally trip the rails inside the turn-off window
  turnoff_delay_a: assert property ( // R4
    (state_q == psfs_pkg::PSFS_RUN) && req_db_n && !fault_set && !fault_q
    |=> (state_q == psfs_pkg::PSFS_STOP) && !fault_protect_n_o)
    else $error("rails dropped before turn-off delay");
  stop_hold_a: assert property ( // R4
    (state_q == psfs_pkg::PSFS_STOP) && !fault_set && !fault_q |=> !fault_protect_n_o)
    else $error("rails dropped inside turn-off delay");
  off_fpo_a: assert property ((state_q == psfs_pkg::PSFS_OFF) |=> fault_protect_n_o) // R5 R8
    else $error("rails enabled while off");
  uv_latch_a: assert property ( // R6
    uv_any && (state_q == psfs_pkg::PSFS_RUN) |=> fault_q && !power_good_out_o)
    else $error("undervoltage not latched");
  ov_latch_a: assert property (ov_any |=> fault_q && fault_protect_n_o && !power_good_out_o) // R7
    else $error("overvoltage not latched");
  pg_drop_a: assert property (!pg_flt |=> !power_good_out_o) // R10
    else $error("power good high without filtered input");
  pg_rise_a: assert property ($rose(power_good_out_o) |-> $past(pg_flt) && !fault_q) // R9
    else $error("power good rose without delay");

  run_c: cover property (state_q == psfs_pkg::PSFS_RUN);
  pg_c: cover property ($rose(power_good_out_o));
  fault_c: cover property ($rose(fault_q));
  stop_c: cover property ((state_q == psfs_pkg::PSFS_STOP) ##1 (state_q == psfs_pkg::PSFS_OFF));

endmodule
`default_nettype wire

// file: testbench/psfs_rail_model.sv
// Converter model: raises the power-good input once the rails have ramped
`timescale 1ns/1ps
`default_nettype none
module psfs_rail_model #(
  parameter int RAMP_CYC = 4
) (
  input wire logic clk_i,              // Timebase clock
  input wire logic rstn_i,             // Async reset, active low
  input wire logic fault_protect_n_i,  // High = rails held off
  output logic power_good_in_o         // Converter healthy
);
  int ramp_cnt;

  // Rails collapse when disabled, so the input drops at the next falling clock edge
  always @(negedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i || fault_protect_n_i)
    begin
      ramp_cnt = 0;
      power_good_in_o <= 1'b0;
    end
    else if (ramp_cnt < RAMP_CYC)
    begin
      ramp_cnt++;
    end
    else
    begin
      power_good_in_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: testbench/psfs_supervisor_tb.sv
// Self-checking testbench for the power supply fault supervisor
`timescale 1ns/1ps
`default_nettype none
module psfs_supervisor_tb;
  localparam int DEB = 8;
  localparam int BLK = 20;
  localparam int TOF = 6;
  localparam int UVG = 5;
  localparam int OVG = 3;
  localparam int PGS = 30;
  localparam int PGL = 60;
  localparam int PGF = 5;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic req_n = 1'b1;
  logic pgi;
  logic pgi_model;
  // Converter good signal forced low by the bench to model a brown-out
  logic pgi_drop = 1'b0;
  logic pgo_long;
  psfs_pkg::psfs_rail_flags_t rail = '0;
  logic fault_protect_n, fpo_oe, power_good_out, pgo_oe, flt;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;

  always #12.5 clk_i = ~clk_i;

  psfs_supervisor #(.DEBOUNCE_CYC(DEB), .UV_BLANK_CYC(BLK), .TURNOFF_CYC(TOF),
    .UV_GLITCH_CYC(UVG), .OV_GLITCH_CYC(OVG), .PG_SHORT_CYC(PGS), .PG_LONG_CYC(PGL),
    .PG_FALL_CYC(PGF)) i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .on_off_request_n_i(req_n),
    .power_good_in_i(pgi), .rail_i(rail), .fault_protect_n_o(fault_protect_n),
    .fault_protect_n_oe_o(fpo_oe), .power_good_out_o(power_good_out), .power_good_out_oe_o(pgo_oe),
    .fault_latched_o(flt));

  // Long delay variant shares every input; only its power good output is judged
  psfs_supervisor #(.LONG_PG_DELAY(1'b1), .DEBOUNCE_CYC(DEB), .UV_BLANK_CYC(BLK),
    .TURNOFF_CYC(TOF), .UV_GLITCH_CYC(UVG), .OV_GLITCH_CYC(OVG), .PG_SHORT_CYC(PGS),
    .PG_LONG_CYC(PGL), .PG_FALL_CYC(PGF)) i_dut_long (.clk_i(clk_i), .rstn_i(rstn_i),
    .on_off_request_n_i(req_n), .power_good_in_i(pgi), .rail_i(rail),
    .fault_protect_n_o(), .fault_protect_n_oe_o(), .power_good_out_o(pgo_long),
    .power_good_out_oe_o(), .fault_latched_o());

  psfs_rail_model i_rails (.clk_i(clk_i), .rstn_i(rstn_i), .fault_protect_n_i(fault_protect_n),
    .power_good_in_o(pgi_model));

  assign pgi = pgi_model & ~pgi_drop;

  // ----------------------------------------------------------------
  // Compare and wait helpers
  // ----------------------------------------------------------------
  task automatic chk_bit(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask

  task automatic chk_range(input int got, input int lo, input int hi, input string what);
    total_checks++;
    if (got < lo || got > hi)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s took %0d cycles", $time, what, got);
    end
  endtask

  task automatic step(input int cnt);
    repeat (cnt) @(negedge clk_i);
  endtask

  // Bounded wait so a stuck output cannot hang the run
  task automatic wait_fpo(input logic v, output int cnt);
    cnt = 0;
    while (fault_protect_n !== v && cnt < 200)
    begin
      @(negedge clk_i);
      cnt++;
    end
  endtask

  task automatic power_on();
    req_n = 1'b0;
    wait_fpo(1'b0, n);
    chk_range(n, DEB, DEB + 6, "turn-on");
  endtask

  // Request high clears the latch; rails are enabled through the turn-off delay, then stay off
  task automatic clear_fault();
    req_n = 1'b1;
    step(DEB + TOF + 8);
    chk_bit(flt, 1'b0, "latch clear");
    chk_bit(fault_protect_n, 1'b1, "off after clear");
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_glitch();
    req_n = 1'b0;
    step(DEB - 2);
    req_n = 1'b1;
    repeat (DEB + 10)
    begin
      step(1);
      chk_bit(fault_protect_n, 1'b1, "short request pulse");
    end
  endtask

  task automatic t_blank_pg();
    power_on();
    chk_bit(fpo_oe, 1'b1, "fault pin pulled low");
    rail.uv_3v3 = 1'b1;
    step(BLK - 8);
    rail = '0;
    chk_bit(flt, 1'b0, "undervoltage in blanking");
    chk_bit(power_good_out, 1'b0, "power good too early");
    n = 0;
    while (power_good_out !== 1'b1 && n < BLK + PGS + 40)
    begin
      step(1);
      n++;
    end
    chk_range(n, PGS, BLK + PGS + 20, "power good rise");
    chk_bit(pgo_long, 1'b0, "long power good early");
    n = 0;
    while (pgo_long !== 1'b1 && n < PGL)
    begin
      step(1);
      n++;
    end
    chk_range(n, PGL - PGS - 2, PGL - PGS + 2, "long power good rise");
    rail.uv_5v = 1'b1;
    step(UVG - 2);
    rail = '0;
    step(2);
    chk_bit(flt, 1'b0, "short undervoltage");
    chk_bit(power_good_out, 1'b1, "power good kept");
    pgi_drop = 1'b1;
    step(PGF - 1);
    chk_bit(power_good_out, 1'b1, "short power good input drop");
    step(3);
    chk_bit(power_good_out, 1'b0, "power good input drop");
    pgi_drop = 1'b0;
    n = 0;
    while (power_good_out !== 1'b1 && n < PGS + 20)
    begin
      step(1);
      n++;
    end
    chk_range(n, PGS, PGS + 2, "power good recovery");
    req_n = 1'b1;
    wait_fpo(1'b1, n);
    chk_range(n, DEB + TOF, DEB + TOF + 6, "turn-off delay");
    chk_bit(power_good_out, 1'b0, "power good after off");
  endtask

  task automatic t_uv_fault();
    power_on();
    step(BLK + 4);
    rail.uv_5v = 1'b1;
    step(UVG + 3);
    chk_bit(flt, 1'b1, "undervoltage latch");
    chk_bit(fault_protect_n, 1'b1, "undervoltage rails off");
    chk_bit(power_good_out, 1'b0, "undervoltage power good");
    rail = '0;
    step(10);
    chk_bit(fault_protect_n, 1'b1, "fault held with request low");
    req_n = 1'b1;
    rstn_i = 1'b0;
    step(2);
    rstn_i = 1'b1;
    step(2);
    chk_bit(flt, 1'b0, "supply loss clears latch");
    chk_bit(fault_protect_n, 1'b1, "off after supply loss");
  endtask

  task automatic t_ov_fault();
    for (int i = 0; i < 3; i++)
    begin
      power_on();
      rail = psfs_pkg::psfs_rail_flags_t'(5'h04 << i);
      step(OVG - 1);
      rail = '0;
      step(2);
      chk_bit(flt, 1'b0, "short overvoltage");
      rail = psfs_pkg::psfs_rail_flags_t'(5'h04 << i);
      step(OVG + 3);
      chk_bit(flt, 1'b1, "overvoltage latch");
      chk_bit(fault_protect_n, 1'b1, "overvoltage rails off");
      chk_bit(pgo_oe, 1'b1, "overvoltage power good");
      rail = '0;
      clear_fault();
    end
  endtask

  // ----------------------------------------------------------------
  // Verdict and watchdog
  // ----------------------------------------------------------------
  task automatic wrap_up();
    if (error_cnt == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      $display("mismatch at %0t: run did not finish", $time);
      wrap_up();
    end
  end

  initial
  begin
    step(16);
    chk_bit(fault_protect_n, 1'b1, "reset fault pin");
    chk_bit(power_good_out, 1'b0, "reset power good");
    rstn_i = 1'b1;
    step(2);
    t_glitch();
    t_blank_pg();
    t_uv_fault();
    t_ov_fault();
    wrap_up();
  end
endmodule
`default_nettype wire
